// ### slb_map.vh
`ifndef SLB_MAP_VH
`define SLB_MAP_VH
// ---------------------------------------------------------------------
// Sector geometry
// ---------------------------------------------------------------------
`define SLB_LAST_BYTE   9'h1ff
`define SLB_SEL_THR     2'h0
`define SLB_SEL_DIR     2'h1
`define SLB_SEL_ERR     2'h2
// ---------------------------------------------------------------------
// Threshold sector
// ---------------------------------------------------------------------
`define SLB_THR_REV     8'h10
`define SLB_THR_BASE    9'h002
`define SLB_THR_END     9'h16a
`define SLB_THR_ENTRY   9'h00c
`define SLB_THR_NUM     5'h1e
`define SLB_THR_DEFAULT 8'h32
// ---------------------------------------------------------------------
// Log directory
// ---------------------------------------------------------------------
`define SLB_DIR_VER     8'h01
`define SLB_DIR_ERRLOG  8'h01
`define SLB_DIR_VLO     8'h80
`define SLB_DIR_VHI     8'h9f
`define SLB_DIR_VLEN    8'h10
`define SLB_DIR_ERRLEN  8'h01
// ---------------------------------------------------------------------
// Error log sector
// ---------------------------------------------------------------------
`define SLB_ERR_VER     8'h01
`define SLB_ERR_BASE    9'h002
`define SLB_ERR_END     9'h1c4
`define SLB_ERR_ENTRY   9'h05a
`define SLB_ERR_CNT_LO  9'h1c4
`define SLB_ERR_CNT_HI  9'h1c5
`define SLB_ERR_REC     7'h3c
`define SLB_ERR_SNAP    7'h0c
`define SLB_ERR_TS      4'h8
`define SLB_REC_STATE   7'h1b
`define SLB_REC_HRS     7'h1c
`define SLB_PTR_EMPTY   3'h0
`define SLB_PTR_MAX     3'h5
`define SLB_CNT_MAX     16'hffff
`endif

// ### slb_fifo.v
`timescale 1ns/1ps
`default_nettype none
module slb_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW    = 2
) (
   input  wire             clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output reg  [WIDTH-1:0] out_data,
   output reg              out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr;
   reg [AW-1:0]    rd_ptr;
   reg [AW:0]      count;
   wire            push;
   wire            pop;
   localparam [AW:0] DEPTH_W = DEPTH;
   // Output stage is a register so the consumer sees no comb path
   assign in_ready = (count < DEPTH_W);
   assign push = in_valid && in_ready;
   assign pop  = (count != {(AW+1){1'b0}}) && (!out_valid || out_ready);
   always @(posedge clk) begin
      if (rst) begin
         wr_ptr    <= {AW{1'b0}};
         rd_ptr    <= {AW{1'b0}};
         count     <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
         out_data  <= {WIDTH{1'b0}};
      end else begin
         if (push) begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= wr_ptr + 1'b1;
         end
         if (pop) begin
            out_data <= mem[rd_ptr];
            rd_ptr   <= rd_ptr + 1'b1;
         end
         if (pop)
            out_valid <= 1'b1;
         else if (out_ready)
            out_valid <= 1'b0;
         if (push && !pop)
            count <= count + 1'b1;
         else if (pop && !push)
            count <= count - 1'b1;
      end
   end
endmodule // slb_fifo
`default_nettype wire

// ### slb_sum.v
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------
// Running modular sum; checksum byte is its negation
// ---------------------------------------------------------------------
module slb_sum (
   input  wire       clk,
   input  wire       rst,
   input  wire       clear,
   input  wire       add,
   input  wire [7:0] data,
   output wire [7:0] check
);
   reg [7:0] sum;
   assign check = 8'h00 - sum;
   always @(posedge clk) begin
      if (rst || clear)
         sum <= 8'h00;
      else if (add)
         sum <= sum + data;
   end
endmodule // slb_sum
`default_nettype wire

// ### slb_builder.v
`timescale 1ns/1ps
`default_nettype none
`include "slb_map.vh"
module slb_builder (
   input  wire        REF_CLK,
   input  wire        RST,
   input  wire        SECT_REQ,
   input  wire [1:0]  SECT_SEL,
   output reg         BUSY,
   output wire [7:0]  RD_DATA,
   output wire        RD_VALID,
   input  wire        RD_READY,
   input  wire        THR_WE,
   input  wire [4:0]  THR_IDX,
   input  wire [7:0]  THR_ID,
   input  wire [7:0]  THR_VAL,
   input  wire        CMD_PUSH,
   input  wire [63:0] CMD_REGS,
   input  wire [31:0] CMD_MS,
   input  wire        ERR_LOG,
   input  wire [55:0] ERR_REGS,
   input  wire [7:0]  ERR_STATE,
   input  wire [15:0] ERR_HOURS
);
   // ------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------
   localparam S_IDLE = 2'b01;
   localparam S_RUN  = 2'b10;
   reg  [7:0]  thr_id   [0:29];
   reg  [7:0]  thr_val  [0:29];
   reg  [95:0] snap     [0:4];
   reg  [95:0] ent_snap [0:24];
   reg  [79:0] ent_rec  [0:4];
   reg  [2:0]  ptr;
   reg  [15:0] err_cnt;
   reg  [1:0]  state;
   reg  [1:0]  sel;
   reg  [8:0]  idx;
   reg         pend;
   reg  [79:0] pend_rec;
   reg  [7:0]  byte_now;
   wire [7:0]  check;
   wire        in_ready;
   wire        run;
   wire        step;
   wire [79:0] new_rec;
   wire [2:0]  next_ptr;
   wire [15:0] next_cnt;
   integer     i;
   integer     j;
   assign run  = (state == S_RUN);
   assign step = run && in_ready;
   assign new_rec  = {ERR_HOURS, ERR_STATE, ERR_REGS};
   assign next_ptr = (ptr == `SLB_PTR_MAX) ? 3'h1 : ptr + 3'h1;
   assign next_cnt = (err_cnt == `SLB_CNT_MAX) ? err_cnt
                                                : err_cnt + 16'h0001;
   // ------------------------------------------------------------------
   // Factory attribute ids; unused slots stay all zero
   // ------------------------------------------------------------------
   function [7:0] factory_id;
      input [4:0] n;
      begin
         case (n)
            5'h00:   factory_id = 8'h01;
            5'h01:   factory_id = 8'h03;
            5'h02:   factory_id = 8'h05;
            5'h03:   factory_id = 8'h07;
            5'h04:   factory_id = 8'h0a;
            5'h05:   factory_id = 8'hc4;
            5'h06:   factory_id = 8'hc5;
            5'h07:   factory_id = 8'hdf;
            default: factory_id = 8'h00;
         endcase
      end
   endfunction
   // Byte lane of a little-endian word
   function [7:0] lane;
      input [95:0] w;
      input [3:0]  b;
      begin
         lane = w[b*8 +: 8];
      end
   endfunction
   // ------------------------------------------------------------------
   // Threshold table and command history
   // ------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 30; g = g + 1) begin : g_thr
         // Genvars take no part-select, so the slot number is sized here
         localparam [4:0] SLOT = g;
         always @(posedge REF_CLK) begin
            if (RST) begin
               thr_id[g]  <= factory_id(SLOT);
               thr_val[g] <= (factory_id(SLOT) == 8'h00) ? 8'h00
                             : `SLB_THR_DEFAULT;
            end else if (THR_WE && !run && THR_IDX == SLOT) begin
               thr_id[g]  <= THR_ID;
               thr_val[g] <= THR_VAL;
            end
         end
      end
      for (g = 0; g < 5; g = g + 1) begin : g_snap
         // Newest command sits in the last slot
         always @(posedge REF_CLK) begin
            if (RST)
               snap[g] <= 96'h0;
            else if (CMD_PUSH)
               snap[g] <= (g == 4) ? {CMD_MS, CMD_REGS}
                                   : snap[(g + 1) % 5];
         end
      end
   endgenerate
   // ------------------------------------------------------------------
   // Error capture; records held back while a sector streams so none tears, but the count updates at once
   // ------------------------------------------------------------------
   always @(posedge REF_CLK) begin
      if (RST) begin
         ptr      <= `SLB_PTR_EMPTY;
         err_cnt  <= 16'h0000;
         pend     <= 1'b0;
         pend_rec <= 80'h0;
         for (i = 0; i < 25; i = i + 1)
            ent_snap[i] <= 96'h0;
         for (i = 0; i < 5; i = i + 1)
            ent_rec[i] <= 80'h0;
      end else begin
         if (ERR_LOG)
            err_cnt <= next_cnt;
         if (ERR_LOG && run) begin
            pend     <= 1'b1;
            pend_rec <= new_rec;
         end else if (!run && (ERR_LOG || pend)) begin
            // Only the last held error keeps its record; earlier ones just count
            pend <= 1'b0;
            ptr  <= next_ptr;
            ent_rec[next_ptr - 3'h1] <= ERR_LOG ? new_rec : pend_rec;
            for (j = 0; j < 5; j = j + 1)
               ent_snap[(next_ptr - 3'h1) * 5 + j] <= snap[j];
         end
      end
   end
   // ------------------------------------------------------------------
   // Byte generator
   // ------------------------------------------------------------------
   reg [8:0] rel;
   reg [4:0] ent;
   reg [6:0] off;
   reg [2:0] sn;
   reg [3:0] sb;
   reg [6:0] ro;
   reg [2:0] e5;
   reg [7:0] la;
   reg [8:0] quo;
   reg [8:0] rem;
   reg [6:0] sq;
   reg [6:0] sr;
   always @* begin
      quo      = 9'h0;
      rem      = 9'h0;
      sq       = 7'h0;
      sr       = 7'h0;
      rel      = 9'h0;
      ent      = 5'h0;
      off      = 7'h0;
      sn       = 3'h0;
      sb       = 4'h0;
      ro       = 7'h0;
      e5       = 3'h0;
      la       = 8'h00;
      byte_now = 8'h00;
      if (idx == `SLB_LAST_BYTE) begin
         byte_now = check;
      end else if (sel == `SLB_SEL_THR) begin
         if (idx == 9'h000) begin
            byte_now = `SLB_THR_REV;
         end else if (idx >= `SLB_THR_BASE && idx < `SLB_THR_END) begin
            rel = idx - `SLB_THR_BASE;
            quo = rel / `SLB_THR_ENTRY;
            rem = rel % `SLB_THR_ENTRY;
            ent = quo[4:0];
            off = rem[6:0];
            if (off == 7'h00)
               byte_now = thr_id[ent];
            else if (off == 7'h01)
               byte_now = thr_val[ent];
         end
      end else if (sel == `SLB_SEL_DIR) begin
         la = idx[8:1];
         if (idx == 9'h000)
            byte_now = `SLB_DIR_VER;
         else if (idx[0] == 1'b0 && la == `SLB_DIR_ERRLOG)
            byte_now = `SLB_DIR_ERRLEN;
         else if (idx[0] == 1'b0 && la >= `SLB_DIR_VLO
                  && la <= `SLB_DIR_VHI)
            byte_now = `SLB_DIR_VLEN;
      end else begin
         if (idx == 9'h000) begin
            byte_now = `SLB_ERR_VER;
         end else if (idx == 9'h001) begin
            byte_now = {5'h00, ptr};
         end else if (idx == `SLB_ERR_CNT_LO) begin
            byte_now = err_cnt[7:0];
         end else if (idx == `SLB_ERR_CNT_HI) begin
            byte_now = err_cnt[15:8];
         end else if (idx >= `SLB_ERR_BASE && idx < `SLB_ERR_END) begin
            rel = idx - `SLB_ERR_BASE;
            quo = rel / `SLB_ERR_ENTRY;
            rem = rel % `SLB_ERR_ENTRY;
            e5  = quo[2:0];
            off = rem[6:0];
            if (off < `SLB_ERR_REC) begin
               sq = off / `SLB_ERR_SNAP;
               sr = off % `SLB_ERR_SNAP;
               sn = sq[2:0];
               sb = sr[3:0];
               byte_now = lane(ent_snap[e5 * 5 + sn], sb);
            end else begin
               ro = off - `SLB_ERR_REC;
               if (ro >= 7'h01 && ro < 7'h08)
                  byte_now = lane({16'h0, ent_rec[e5]},
                                  ro[3:0] - 4'h1);
               else if (ro == `SLB_REC_STATE)
                  byte_now = ent_rec[e5][63:56];
               else if (ro == `SLB_REC_HRS)
                  byte_now = ent_rec[e5][71:64];
               else if (ro == `SLB_REC_HRS + 7'h01)
                  byte_now = ent_rec[e5][79:72];
            end
         end
      end
   end
   // ------------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------------
   always @(posedge REF_CLK) begin
      if (RST) begin
         state <= S_IDLE;
         sel   <= `SLB_SEL_THR;
         idx   <= 9'h000;
         BUSY  <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               // Unknown selectors are ignored
               if (SECT_REQ && SECT_SEL != 2'h3) begin
                  sel   <= SECT_SEL;
                  idx   <= 9'h000;
                  state <= S_RUN;
                  BUSY  <= 1'b1;
               end
            end
            S_RUN: begin
               if (in_ready) begin
                  if (idx == `SLB_LAST_BYTE) begin
                     state <= S_IDLE;
                     BUSY  <= 1'b0;
                  end
                  idx <= idx + 9'h001;
               end
            end
            default: begin
               state <= S_IDLE;
               BUSY  <= 1'b0;
            end
         endcase
      end
   end
   // ------------------------------------------------------------------
   // Checksum and output buffer; host stalls reach the sequencer
   // ------------------------------------------------------------------
   slb_sum u_sum (
      .clk   (REF_CLK),
      .rst   (RST),
      .clear (!run),
      .add   (step),
      .data  (byte_now),
      .check (check)
   );
   slb_fifo #(
      .WIDTH (8),
      .DEPTH (4),
      .AW    (2)
   ) u_fifo (
      .clk       (REF_CLK),
      .rst       (RST),
      .in_data   (byte_now),
      .in_valid  (run),
      .in_ready  (in_ready),
      .out_data  (RD_DATA),
      .out_valid (RD_VALID),
      .out_ready (RD_READY)
   );
endmodule // slb_builder
`default_nettype wire

// ### slb_builder_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module slb_builder_monitor (
   input wire logic       REF_CLK,
   input wire logic       RST,
   input wire logic       SECT_REQ,
   input wire logic [1:0] SECT_SEL,
   input wire logic       BUSY,
   input wire logic [7:0] RD_DATA,
   input wire logic       RD_VALID,
   input wire logic       RD_READY
);
   // ---------------------------------------------------------------
   // Byte position tracking
   // ---------------------------------------------------------------
   logic [8:0] cnt;
   logic [7:0] sum;
   logic [1:0] sel;
   wire        hs   = RD_VALID && RD_READY;
   wire        take = SECT_REQ && !BUSY && SECT_SEL != 2'h3;
   // Assumes no new request while the previous tail still drains
   always @(posedge REF_CLK) begin
      if (RST) begin
         cnt <= 9'h000;
         sum <= 8'h00;
         sel <= 2'h0;
      end else begin
         if (take)
            sel <= SECT_SEL;
         if (hs) begin
            cnt <= cnt + 9'h001;
            sum <= (cnt == 9'h1ff) ? 8'h00 : sum + RD_DATA;
         end
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_busy_rise: assert property (take |=> BUSY)
      else $error("busy not raised");
   chk_sel_skip: assert property (SECT_REQ && !BUSY && SECT_SEL == 2'h3
      |=> !BUSY) else $error("bad select taken");
   chk_byte_hold: assert property (RD_VALID && !RD_READY
      |=> RD_VALID && $stable(RD_DATA)) else $error("byte dropped");
   chk_first_byte: assert property (take && !RD_VALID
      |-> ##[1:4] RD_VALID) else $error("first byte late");
   chk_sum_zero: assert property (hs && cnt == 9'h1ff
      |-> (sum + RD_DATA) == 8'h00) else $error("checksum wrong");
   chk_thr_rev: assert property (hs && sel == 2'h0 && cnt < 9'h002
      |-> RD_DATA == (cnt[0] ? 8'h00 : 8'h10)) else $error("revision");
   chk_ver_one: assert property (hs && sel != 2'h0 && cnt == 9'h000
      |-> RD_DATA == 8'h01) else $error("version");
   chk_ptr_range: assert property (hs && sel == 2'h2 && cnt == 9'h001
      |-> RD_DATA <= 8'h05) else $error("pointer range");
   chk_dir_vendor: assert property (hs && sel == 2'h1
      && cnt[8:1] >= 8'h80 && cnt[8:1] <= 8'h9f
      |-> RD_DATA == (cnt[0] ? 8'h00 : 8'h10)) else $error("dir length");
   chk_thr_pad: assert property (hs && sel == 2'h0 && cnt >= 9'h16a
      && cnt < 9'h1ff |-> RD_DATA == 8'h00) else $error("pad not zero");
endmodule // slb_builder_monitor
bind slb_builder slb_builder_monitor mon (.REF_CLK(REF_CLK), .RST(RST),
   .SECT_REQ(SECT_REQ), .SECT_SEL(SECT_SEL), .BUSY(BUSY),
   .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .RD_READY(RD_READY));
`default_nettype wire

// ### slb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module slb_host_model (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       valid,
   input wire logic       slow,
   input wire logic [7:0] data,
   output logic           ready
);
   logic [7:0] mem [512];
   int         got;
   // Slow host stalls every other cycle to exercise the queue
   always @(posedge clk) begin
      if (rst) begin
         ready <= 1'b0;
         got <= 0;
      end else begin
         if (valid && ready) begin
            mem[got % 512] <= data;
            got <= got + 1;
         end
         ready <= slow ? !ready : 1'b1;
      end
   end
endmodule // slb_host_model
`default_nettype wire

// ### test_slb_builder.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
 bad_count++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module test_slb_builder;
   logic        ref_clk = 0, rst = 1, sect_req = 0, thr_we = 0;
   logic        cmd_push = 0, err_log = 0, slow = 0;
   logic [1:0]  sect_sel = 0;
   logic [4:0]  thr_idx = 0;
   logic [7:0]  thr_id = 0, thr_val = 0, eid [30], ev [30];
   logic [63:0] cmd_regs = 0;
   logic [31:0] cmd_ms = 0;
   wire         busy, rd_valid, rd_ready;
   wire  [7:0]  rd_data;
   int          bad_count = 0, samples_checked = 0, g0;
   logic [7:0]  fid [8] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h0a, 8'hc4,
                            8'hc5, 8'hdf};
   logic [7:0]  code [5] = '{8'h00, 8'h01, 8'hfd, 8'hfe, 8'hff};
   slb_builder dut (.REF_CLK(ref_clk), .RST(rst), .SECT_REQ(sect_req),
      .SECT_SEL(sect_sel), .BUSY(busy), .RD_DATA(rd_data),
      .RD_VALID(rd_valid), .RD_READY(rd_ready), .THR_WE(thr_we),
      .THR_IDX(thr_idx), .THR_ID(thr_id), .THR_VAL(thr_val),
      .CMD_PUSH(cmd_push), .CMD_REGS(cmd_regs), .CMD_MS(cmd_ms),
      .ERR_LOG(err_log), .ERR_REGS(56'h37363534333231),
      .ERR_STATE(8'hb3), .ERR_HOURS(16'h1234));
   slb_host_model host (.clk(ref_clk), .rst(rst), .valid(rd_valid),
      .slow(slow), .data(rd_data), .ready(rd_ready));
   initial begin
      forever #2 ref_clk = !ref_clk;
   end
   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic go(input logic [1:0] s);
      g0 = host.got;
      @(posedge ref_clk);
      #1 sect_sel = s;
      sect_req = 1;
      @(posedge ref_clk);
      #1 sect_req = 0;
      `CHK(busy, 1'b1)
   endtask
   task automatic fin;
      int k;
      logic [7:0] sum;
      sum = 0;
      for (k = 0; k < 3000 && host.got != g0 + 512; k++) @(posedge ref_clk);
      `CHK(host.got, g0 + 512)
      for (k = 0; k < 512; k++) sum += host.mem[k];
      `CHK(sum, 8'h00)
   endtask
   task automatic rd(input logic [1:0] s);
      go(s);
      fin;
   endtask
   task automatic wthr(input int x, input logic [7:0] id, v, input bit keep);
      @(posedge ref_clk);
      #1 thr_we = 1;
      thr_idx = x[4:0];
      thr_id = id;
      thr_val = v;
      if (x < 30 && keep) begin
         eid[x] = id;
         ev[x] = v;
      end
      @(posedge ref_clk);
      #1 thr_we = 0;
   endtask
   task automatic err(input int n);
      @(posedge ref_clk);
      #1 err_log = 1;
      repeat (n) @(posedge ref_clk);
      #1 err_log = 0;
   endtask
   task automatic hdr(input logic [7:0] p, input logic [15:0] c);
      rd(2);
      `CHK(host.mem[0], 8'h01)
      `CHK(host.mem[1], p)
      `CHK({host.mem['h1c5], host.mem['h1c4]}, c)
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_thr;
      int i;
      logic [7:0] e;
      rd(0);
      for (i = 0; i < 511; i++) begin
         e = (i == 0) ? 8'h10 : 8'h00;
         if (i >= 2 && i < 'h16a && (i - 2) % 12 < 2)
            e = ((i - 2) % 12) ? ev[(i - 2) / 12] : eid[(i - 2) / 12];
         `CHK(host.mem[i], e)
      end
   endtask
   task automatic t_dir;
      int i;
      logic [7:0] e;
      rd(1);
      for (i = 0; i < 511; i++) begin
         e = (i == 0 || i == 2) ? 8'h01 : 8'h00;
         if (i % 2 == 0 && i / 2 >= 'h80 && i / 2 <= 'h9f) e = 8'h10;
         `CHK(host.mem[i], e)
      end
   endtask
   task automatic t_err;
      int j, s, b;
      logic [7:0] e;
      for (s = 1; s <= 6; s++) begin
         @(posedge ref_clk);
         #1 cmd_push = 1;
         cmd_regs = {8{s[7:0]}} ^ 64'h0706050403020100;
         cmd_ms = 32'h0a0b0c00 | s;
      end
      @(posedge ref_clk);
      #1 cmd_push = 0;
      err(1);
      hdr(8'h01, 16'h0001);
      for (j = 0; j < 90; j++) begin
         s = j / 12 + 2;
         b = j % 12;
         e = b < 8 ? s[7:0] ^ b[7:0] : b == 8 ? s[7:0] : 8'h15 - b[7:0];
         b = j - 60;
         if (j >= 60)
            e = (b > 0 && b < 8) ? 8'h30 + b[7:0] : b == 27 ? 8'hb3 :
                b == 28 ? 8'h34 : b == 29 ? 8'h12 : 8'h00;
         `CHK(host.mem[2 + j], e)
      end
      // Error during a read is held and committed afterwards
      go(2);
      err(1);
      fin;
      hdr(8'h02, 16'h0002);
      err(4);
      hdr(8'h01, 16'h0006);
      err(65536);
      hdr(8'h02, 16'hffff);
   endtask
   task wrap_up;
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 30; i++) begin
         eid[i] = (i < 8) ? fid[i] : 8'h00;
         ev[i] = (i < 8) ? 8'h32 : 8'h00;
      end
      repeat (6) @(posedge ref_clk);
      #1 rst = 0;
      t_thr;
      slow = 1;
      for (int k = 0; k < 5; k++) wthr(8 + k, 8'h20 + k, code[k], 1);
      wthr(29, 8'hff, 8'h7f, 1);
      wthr(30, 8'h55, 8'h55, 1);
      go(0);
      wthr(1, 8'h99, 8'h99, 0);
      fin;
      t_thr;
      @(posedge ref_clk);
      #1 sect_sel = 2'h3;
      sect_req = 1;
      @(posedge ref_clk);
      #1 sect_req = 0;
      `CHK(busy, 1'b0)
      t_dir;
      slow = 0;
      t_err;
      wrap_up;
   end
   // Covers the long saturation run plus every sector read
   initial begin
      #600000;
      bad_count++;
      wrap_up;
   end
endmodule // test_slb_builder
`default_nettype wire
